// *** dv/sac_core_model.sv ***
// analog core stand-in: fixed code per channel and reference
// assumes one-cycle ticks from the control block while sampling
`timescale 1ns/10ps
`default_nettype none
module sac_core_model (
	input wire logic clk_in,
	input wire logic sample_in,
	input wire logic tick_in,
	input wire logic [3:0] channel_in,
	input wire logic ref_ext_in,
	output logic done_out,
	output logic [11:0] result_out
);
	logic [5:0] cnt_q;
	always_ff @(posedge clk_in)
		cnt_q <= sample_in ? cnt_q + 6'(tick_in) : 6'h00;
	assign done_out = tick_in && cnt_q == 6'h3B;
	assign result_out = {channel_in, 3'h5, ref_ext_in, channel_in};
endmodule
`default_nettype wire

// *** dv/sac_top_sva.sv ***
// port assertions for the converter control unit
// assumes bind into sac_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module sac_top_sva (
	input wire logic CORE_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic CORE_POWER_DOWN_OUT,
	input wire logic CORE_SAMPLE_OUT,
	input wire logic CORE_CLK_TICK_OUT,
	input wire logic [3:0] CORE_CHANNEL_OUT,
	input wire logic CORE_INTERNAL_CH_OUT,
	input wire logic CONV_DONE_PULSE_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	logic [6:0] tick_cnt_q;
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
			tick_cnt_q <= 7'h00;
		else
			tick_cnt_q <= CORE_SAMPLE_OUT ?
				tick_cnt_q + 7'(CORE_CLK_TICK_OUT) : 7'h00;
	sequence s_finish;
		CONV_DONE_PULSE_OUT;
	endsequence
	done_pulse_a: assert property (s_finish |=> !CONV_DONE_PULSE_OUT)
		else $error("done pulse too long");
	done_cause_a: assert property (s_finish |-> $past(CORE_SAMPLE_OUT))
		else $error("done without conversion");
	conv_ends_a: assert property (s_finish |=> !CORE_SAMPLE_OUT)
		else $error("sampling after done");
	conv_len_a: assert property (s_finish |->
		(tick_cnt_q + 7'(CORE_CLK_TICK_OUT)) == 7'h3C)
		else $error("wrong tick count");
	tick_busy_a: assert property (CORE_CLK_TICK_OUT |-> CORE_SAMPLE_OUT)
		else $error("tick while idle");
	tick_gap_a: assert property (CORE_CLK_TICK_OUT |=> !CORE_CLK_TICK_OUT)
		else $error("ticks too close");
	pd_idle_a: assert property (CORE_POWER_DOWN_OUT [*2] |-> !CORE_SAMPLE_OUT)
		else $error("converting in power down");
	int_chan_a: assert property
		(CORE_INTERNAL_CH_OUT == (CORE_CHANNEL_OUT == 4'hF))
		else $error("internal channel mismatch");
endmodule
bind sac_top sac_top_sva u_sva (.CORE_CLK_IN(CORE_CLK_IN),
	.ARST_N_IN(ARST_N_IN), .CORE_POWER_DOWN_OUT(CORE_POWER_DOWN_OUT),
	.CORE_SAMPLE_OUT(CORE_SAMPLE_OUT), .CORE_CLK_TICK_OUT(CORE_CLK_TICK_OUT),
	.CORE_CHANNEL_OUT(CORE_CHANNEL_OUT),
	.CORE_INTERNAL_CH_OUT(CORE_INTERNAL_CH_OUT),
	.CONV_DONE_PULSE_OUT(CONV_DONE_PULSE_OUT));
`default_nettype wire

// *** dv/tb_top.sv ***
// apb bench for the converter control unit
// assumes sac_top, the core model and the checker compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rdata;
	logic rdy, serr, err, pd, smp, tick, refx, intch, cdone, irq, done;
	logic [4:0] ev = 5'h00;
	logic [3:0] chan, ch;
	logic [11:0] res, cres;
	logic [7:0] hi, lo;
	int fail_count = 0, compares = 0, k, i, g;
	int dv[4] = '{2, 4, 8, 32};
	logic [2:0] src[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
	always #10 clk = ~clk;
	sac_top #(.ZERO_OFFSET(8'hE7)) u_dut (
		.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
		.PSTRB_IN(4'hF), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
		.PSLVERR_OUT(serr), .TRIG_EVENTS_IN(ev), .CORE_DONE_IN(done),
		.CORE_RESULT_IN(cres), .CORE_POWER_DOWN_OUT(pd),
		.CORE_SAMPLE_OUT(smp), .CORE_CLK_TICK_OUT(tick),
		.CORE_CHANNEL_OUT(chan), .CORE_REF_EXT_OUT(refx),
		.CORE_INTERNAL_CH_OUT(intch), .CONV_DONE_PULSE_OUT(cdone),
		.IRQ_OUT(irq));
	sac_core_model u_core (.clk_in(clk), .sample_in(smp), .tick_in(tick),
		.channel_in(chan), .ref_ext_in(refx), .done_out(done),
		.result_out(cres));
	task automatic summarize;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (!rdy)
			@(posedge clk);
		rdata = prd;
		err = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata, {24'h0, e});
	endtask
	task automatic quiet(input int n);
		for (int j = 0; j < n; j++) begin
			@(posedge clk);
			chk(smp | cdone, 1'b0);
		end
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 5'h00;
	endtask
	task automatic wdone;
		int n, t1;
		n = 0;
		t1 = 0;
		g = 0;
		while (!cdone && n < 3000) begin
			@(posedge clk);
			n++;
			if (tick && t1 == 0)
				t1 = n;
			else if (tick && g == 0)
				g = n - t1;
		end
		chk(cdone, 1'b1);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		rd(12'h254, 8'h8F);
		rd(12'h258, 8'h01);
		rd(12'h308, 8'hE7);
		rd(12'h3FC, 8'h00);
		chk(err, 1'b1);
		apb(1'b1, 12'h304, 32'h1);
		for (k = 0; k < 4; k++) begin
			ch = 4'hC + 4'(k);
			res = {ch, 3'h5, k[1], ch};
			hi = k[0] ? {4'h0, res[11:8]} : res[11:4];
			lo = k[0] ? res[7:0] : {res[3:0], 4'h0};
			apb(1'b1, 12'h258, {29'h0, k[0], k[1:0]});
			apb(1'b1, 12'h254, {24'h0, 2'b01, k[1], 1'b0, ch});
			@(posedge clk);
			chk({smp, refx, intch, chan}, {1'b1, k[1], ch == 4'hF, ch});
			rd(12'h254, {2'b01, k[1], 1'b0, ch});
			wdone();
			chk(g, dv[k]);
			rd(12'h254, {2'b00, k[1], 1'b1, ch});
			rd(12'h25C, hi);
			rd(12'h258, lo);
			chk(irq, 1'b1);
			apb(1'b1, 12'h300, 32'h1);
			rd(12'h25C, hi);
			chk(irq, 1'b0);
		end
		apb(1'b1, 12'h254, 32'h4F);
		apb(1'b1, 12'h254, 32'h0F);
		quiet(100);
		apb(1'b1, 12'h254, 32'h8F);
		apb(1'b1, 12'h254, 32'hCF);
		chk(pd, 1'b1);
		rd(12'h258, 8'h07);
		quiet(30);
		apb(1'b1, 12'h254, 32'h0F);
		apb(1'b1, 12'h304, 32'h0);
		for (i = 0; i < 5; i++) begin
			apb(1'b1, 12'h258, {24'h0, 1'b1, src[i], 4'h3});
			pulse(5'h1F ^ (5'h01 << i));
			quiet(20);
			pulse(5'h01 << i);
			wdone();
			apb(1'b0, 12'h300, 32'h0);
			chk(rdata[0], 1'b1);
			chk(irq, 1'b0);
			apb(1'b1, 12'h300, 32'h3);
		end
		apb(1'b1, 12'h258, 32'h00);
		pulse(5'h01);
		quiet(20);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule
`default_nettype wire

// *** hdl/sac_clkdiv.sv ***
// converter clock divider: one-cycle tick per converter clock period
// assumes same clock domain as the control block
`timescale 1ns/10ps
`default_nettype none
module sac_clkdiv #(
	parameter int CNT_W = 5
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic run_in,
	input wire logic [1:0] div_sel_in,
	output logic tick_out
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] limit;

	always_comb begin
		case (div_sel_in)
		2'h0: limit = CNT_W'(1);
		2'h1: limit = CNT_W'(3);
		2'h2: limit = CNT_W'(7);
		default: limit = CNT_W'(31);
		endcase
	end

	// divide by 2, 4, 8 or 32
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= '0;
		end else if (!run_in || cnt_q >= limit) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	assign tick_out = run_in && (cnt_q >= limit);
endmodule
`default_nettype wire

// *** hdl/sac_pkg.sv ***
// types shared by the converter control block
// assumes no other packages
package sac_pkg;
	typedef enum logic [2:0] {
		SAC_TRIG_EXT0 = 3'h0,
		SAC_TRIG_EXT1 = 3'h1,
		SAC_TRIG_TMR0 = 3'h4,
		SAC_TRIG_TMR1 = 3'h5,
		SAC_TRIG_TMR2 = 3'h6
	} sac_trig_e;
	typedef enum logic [1:0] {
		SAC_DIV2 = 2'h0,
		SAC_DIV4 = 2'h1,
		SAC_DIV8 = 2'h2,
		SAC_DIV32 = 2'h3
	} sac_div_e;
	typedef enum {
		SAC_IDLE,
		SAC_BUSY
	} sac_state_e;
endpackage

// *** hdl/sac_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from design files
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// byte addresses on apb (index times four)
`define SAC_IDX_CONTROL 8'h95
`define SAC_IDX_RES_LOW 8'h96
`define SAC_IDX_TRIG_CFG 8'h96
`define SAC_IDX_RES_HIGH 8'h97
`define SAC_ADDR_CONTROL 12'h254
`define SAC_ADDR_SHARED 12'h258
`define SAC_ADDR_RES_HIGH 12'h25C
`define SAC_ADDR_IRQ_STATUS 12'h300
`define SAC_ADDR_IRQ_MASK 12'h304
`define SAC_ADDR_ZERO_OFFSET 12'h308
`define SAC_OPTION_ADDR_ZERO_OFFSET 16'h4007

// adc_control fields
`define SAC_CTL_POWER_DOWN 7
`define SAC_CTL_START 6
`define SAC_CTL_REFERENCE_SELECT 5
`define SAC_CTL_DONE 4
`define SAC_CTL_RESET 8'h8F

// adc_trigger_clock_config fields
`define SAC_CFG_EXT_TRIG 7
`define SAC_CFG_ALIGN 2
`define SAC_CFG_RESET 8'h01
`define SAC_CFG_WMASK 8'hF7

// conversion length in converter clocks
`define SAC_CONV_CYCLES 60
`define SAC_CONV_CNT_W 6

`endif

// *** hdl/sac_top.sv ***
// converter control unit: apb registers, sequencing, result alignment
// assumes apb master on CORE_CLK_IN; trigger events from other clocks
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "sac_regs.svh"
module sac_top #(
	parameter logic [7:0] ZERO_OFFSET = 8'h00,
	parameter int ADDR_W = 12
) (
	input wire logic CORE_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [3:0] PSTRB_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic [4:0] TRIG_EVENTS_IN,
	input wire logic CORE_DONE_IN,
	input wire logic [11:0] CORE_RESULT_IN,
	output logic CORE_POWER_DOWN_OUT,
	output logic CORE_SAMPLE_OUT,
	output logic CORE_CLK_TICK_OUT,
	output logic [3:0] CORE_CHANNEL_OUT,
	output logic CORE_REF_EXT_OUT,
	output logic CORE_INTERNAL_CH_OUT,
	output logic CONV_DONE_PULSE_OUT,
	output logic IRQ_OUT
);
	logic [7:0] ctl_q;
	logic [7:0] cfg_q;
	logic [7:0] res_hi_q;
	logic [7:0] res_lo_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [4:0] ev_s1_q;
	logic [4:0] ev_s2_q;
	logic [`SAC_CONV_CNT_W-1:0] cnt_q;
	sac_pkg::sac_state_e state_q;
	logic [31:0] rdata_q;
	logic err_q;
	logic acc;
	logic wr;
	logic rd;
	logic tick;
	logic trig;
	logic sw_start;
	logic sw_stop;
	logic finish;
	logic powered;
	logic busy;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [11:0] target);
		hit = (a == ADDR_W'(target));
	endfunction

	assign acc = PSEL_IN && PENABLE_IN;
	assign wr = acc && PWRITE_IN && PSTRB_IN[0];
	assign rd = acc && !PWRITE_IN;
	assign powered = !ctl_q[`SAC_CTL_POWER_DOWN];
	assign busy = (state_q == sac_pkg::SAC_BUSY);

	// two-flop synchroniser for trigger events
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ev_s1_q <= '0;
			ev_s2_q <= '0;
		end else begin
			ev_s1_q <= TRIG_EVENTS_IN;
			ev_s2_q <= ev_s1_q;
		end
	end

	sac_clkdiv #(
		.CNT_W(5)
	) u_div (
		.clk_in(CORE_CLK_IN),
		.arst_n_in(ARST_N_IN),
		.run_in(busy),
		.div_sel_in(cfg_q[1:0]),
		.tick_out(tick)
	);

	sac_trigsel u_trig (
		.clk_in(CORE_CLK_IN),
		.arst_n_in(ARST_N_IN),
		.enable_in(cfg_q[`SAC_CFG_EXT_TRIG] && powered),
		.src_sel_in(cfg_q[6:4]),
		.events_in(ev_s2_q),
		.trig_out(trig)
	);

	// start on one write with power-down clear; stop on zero write, power-down write or ext-trigger clear
	assign sw_start = wr && hit(PADDR_IN, `SAC_ADDR_CONTROL)
		&& PWDATA_IN[`SAC_CTL_START] && !PWDATA_IN[`SAC_CTL_POWER_DOWN];
	assign sw_stop = wr && ((hit(PADDR_IN, `SAC_ADDR_CONTROL)
		&& (!PWDATA_IN[`SAC_CTL_START]
		|| PWDATA_IN[`SAC_CTL_POWER_DOWN]))
		|| (hit(PADDR_IN, `SAC_ADDR_SHARED)
		&& !PWDATA_IN[`SAC_CFG_EXT_TRIG]
		&& cfg_q[`SAC_CFG_EXT_TRIG]));
	assign finish = busy && tick
		&& (cnt_q == `SAC_CONV_CNT_W'(`SAC_CONV_CYCLES - 1));

	// conversion sequencer
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state_q <= sac_pkg::SAC_IDLE;
			cnt_q <= '0;
		end else begin
			case (state_q)
			sac_pkg::SAC_IDLE: begin
				cnt_q <= '0;
				if ((sw_start || (trig && powered)) && !sw_stop) begin
					state_q <= sac_pkg::SAC_BUSY;
				end
			end
			sac_pkg::SAC_BUSY: begin
				if (sw_stop || !powered || finish) begin
					state_q <= sac_pkg::SAC_IDLE;
					cnt_q <= '0;
				end else if (tick) begin
					cnt_q <= cnt_q + `SAC_CONV_CNT_W'(1);
				end
			end
			default: begin
				state_q <= sac_pkg::SAC_IDLE;
			end
			endcase
		end
	end

	// control register; done flag is hardware owned
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ctl_q <= `SAC_CTL_RESET;
		end else begin
			if (wr && hit(PADDR_IN, `SAC_ADDR_CONTROL)) begin
				ctl_q[7:5] <= PWDATA_IN[7:5];
				ctl_q[3:0] <= PWDATA_IN[3:0];
			end
			if (state_q == sac_pkg::SAC_IDLE
				&& (sw_start || (trig && powered)) && !sw_stop) begin
				ctl_q[`SAC_CTL_DONE] <= 1'b0;
			end else if (finish) begin
				ctl_q[`SAC_CTL_DONE] <= 1'b1;
				ctl_q[`SAC_CTL_START] <= 1'b0;
			end
		end
	end

	// config register: writes always reach it
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			cfg_q <= `SAC_CFG_RESET;
		end else if (wr && hit(PADDR_IN, `SAC_ADDR_SHARED)) begin
			cfg_q <= PWDATA_IN[7:0] & `SAC_CFG_WMASK;
		end
	end

	// result load and alignment; held otherwise
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			res_hi_q <= 8'h00;
			res_lo_q <= 8'h00;
		end else if (finish) begin
			if (cfg_q[`SAC_CFG_ALIGN]) begin
				res_hi_q <= {4'h0, CORE_RESULT_IN[11:8]};
				res_lo_q <= CORE_RESULT_IN[7:0];
			end else begin
				res_hi_q <= CORE_RESULT_IN[11:4];
				res_lo_q <= {CORE_RESULT_IN[3:0], 4'h0};
			end
		end
	end

	// sticky status, write-one clear, set wins
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			irq_stat_q <= 2'h0;
			irq_mask_q <= 2'h0;
		end else begin
			if (wr && hit(PADDR_IN, `SAC_ADDR_IRQ_MASK)) begin
				irq_mask_q <= PWDATA_IN[1:0];
			end
			irq_stat_q <= (irq_stat_q & ~((wr
				&& hit(PADDR_IN, `SAC_ADDR_IRQ_STATUS))
				? PWDATA_IN[1:0] : 2'h0))
				| {trig && powered, finish};
		end
	end

	assign IRQ_OUT = |(irq_stat_q & irq_mask_q);

	// read mux; shared address depends on power-down
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rdata_q <= 32'h0;
			err_q <= 1'b0;
		end else if (PSEL_IN && !PENABLE_IN) begin
			err_q <= 1'b0;
			if (hit(PADDR_IN, `SAC_ADDR_CONTROL)) begin
				rdata_q <= {24'h0, ctl_q};
			end else if (hit(PADDR_IN, `SAC_ADDR_SHARED)) begin
				rdata_q <= {24'h0, powered ? res_lo_q : cfg_q};
			end else if (hit(PADDR_IN, `SAC_ADDR_RES_HIGH)) begin
				rdata_q <= {24'h0, res_hi_q};
			end else if (hit(PADDR_IN, `SAC_ADDR_IRQ_STATUS)) begin
				rdata_q <= {30'h0, irq_stat_q};
			end else if (hit(PADDR_IN, `SAC_ADDR_IRQ_MASK)) begin
				rdata_q <= {30'h0, irq_mask_q};
			end else if (hit(PADDR_IN, `SAC_ADDR_ZERO_OFFSET)) begin
				rdata_q <= {24'h0, ZERO_OFFSET};
			end else begin
				rdata_q <= 32'h0;
				err_q <= 1'b1;
			end
		end
	end

	assign PRDATA_OUT = rd ? rdata_q : 32'h0;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = acc && err_q;

	// analog core steering
	assign CORE_POWER_DOWN_OUT = ctl_q[`SAC_CTL_POWER_DOWN];
	assign CORE_SAMPLE_OUT = busy;
	assign CORE_CLK_TICK_OUT = tick;
	assign CORE_CHANNEL_OUT = ctl_q[3:0];
	assign CORE_INTERNAL_CH_OUT = &ctl_q[3:0];
	assign CORE_REF_EXT_OUT = ctl_q[`SAC_CTL_REFERENCE_SELECT];
	assign CONV_DONE_PULSE_OUT = finish;
endmodule
`default_nettype wire

// *** hdl/sac_trigsel.sv ***
// trigger source selector with rising-edge detection
// assumes interrupt event inputs already synchronised to clk_in
`timescale 1ns/10ps
`default_nettype none
module sac_trigsel (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic enable_in,
	input wire logic [2:0] src_sel_in,
	input wire logic [4:0] events_in,
	output logic trig_out
);
	logic sel;
	logic sel_q;

	// source decode, unused codes select nothing
	always_comb begin
		case (src_sel_in)
		sac_pkg::SAC_TRIG_EXT0: sel = events_in[0];
		sac_pkg::SAC_TRIG_EXT1: sel = events_in[1];
		sac_pkg::SAC_TRIG_TMR0: sel = events_in[2];
		sac_pkg::SAC_TRIG_TMR1: sel = events_in[3];
		sac_pkg::SAC_TRIG_TMR2: sel = events_in[4];
		default: sel = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sel_q <= 1'b0;
		end else begin
			sel_q <= sel;
		end
	end

	// raw event edge, independent of interrupt enables
	assign trig_out = enable_in && sel && !sel_q;
endmodule
`default_nettype wire
